/* File: include/pts_consts.vh */
// Notes on behaviour
// - PCI target reaches on-board SDRAM
// - Accept five PCI memory commands
// - Write-and-invalidate handled as plain write
// - No-prefetch line/multiple reads stop at line end; plain reads after one word
// - Device select always medium decode
// - Retry, disconnect with and without data
// - Initial and subsequent latency timers end transfers
// - Locked access excludes other masters
// - Posted writes gathered into 32-byte requests
// - Write FIFO holds 64 bytes
// - Full write FIFO: wait, then disconnect
// - Prefetch issues aligned line reads into FIFO
// - Read end discards prefetched data
// - Wait for read data, else retry/disconnect
// - Reads wait for posted writes completing
// - Drive PCI clock to board and connector
// - Arbiter grants four request/grant pairs
// - Pair 1 outranks others on one variant
// - System error input reported as fatal
// - USB function: AD12 select, function 4
// - Bridge/GPIO function: AD12 select, function 2
`ifndef PTS_CONSTS_VH
`define PTS_CONSTS_VH
`define PTS_CMD_MRD 4'h6
`define PTS_CMD_MWR 4'h7
`define PTS_CMD_CRD 4'ha
`define PTS_CMD_CWR 4'hb
`define PTS_CMD_MRM 4'hc
`define PTS_CMD_MRL 4'he
`define PTS_CMD_MWI 4'hf
`define PTS_FN_GPIO 3'h2
`define PTS_FN_USB 3'h4
`define PTS_INIT_LAT 16
`define PTS_SUBS_LAT 8
`define PTS_LINE_WORDS 8
`define PTS_WF_DEPTH 16
`define PTS_RF_DEPTH 16
`endif

/* File: src/pts_bridge.v */
`timescale 1ns/1ns
`include "pts_consts.vh"

module pts_fifo #(
    parameter W = 32,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0] count
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign count = wp_r - rp_r;
    assign in_ready = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem_r[rp_r[AW-1:0]];
    always @(posedge clk) begin
        if (push)
            mem_r[wp_r[AW-1:0]] <= in_data;
    end
    always @(posedge clk) begin
        if (!rst_n || flush) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule

module pts_bridge #(
    parameter [31:0] MEM_BASE = 32'ha0000000,
    parameter MEM_AW = 26,
    parameter INIT_LAT = `PTS_INIT_LAT,
    parameter SUBS_LAT = `PTS_SUBS_LAT,
    parameter NUM_PAIRS = 4,
    parameter PAIR1_HI = 1,
    parameter [31:0] ID_USB = 32'h00a51234,
    parameter [31:0] ID_GPIO = 32'h00a51235
) (
    input wire clk,
    input wire rst_n,
    input wire pf_en_i,
    input wire [31:0] ad_i,
    output wire [31:0] ad_o,
    output wire ad_oe,
    input wire [3:0] cbe_n_i,
    input wire frame_n_i,
    input wire irdy_n_i,
    input wire idsel_i,
    input wire lock_n_i,
    output wire devsel_n_o,
    output wire trdy_n_o,
    output wire stop_n_o,
    output wire ctl_oe,
    output reg par_o_r,
    output reg par_oe_r,
    input wire serr_n_i,
    output reg sys_err_r,
    input wire [3:0] req_n_i,
    output wire [3:0] gnt_n_o,
    input wire int_req_i,
    output wire int_gnt_o,
    output wire pci_clk0_o,
    output wire pci_clk_conn_o,
    output wire clk_stop_ok_o,
    output reg sd_wr_valid_r,
    input wire sd_wr_ready_i,
    output wire [31:0] sd_wr_addr,
    output reg [255:0] sd_wr_data_r,
    output reg [31:0] sd_wr_mask_r,
    output reg sd_rd_req_r,
    input wire sd_rd_ready_i,
    output wire [31:0] sd_rd_addr,
    input wire sd_rd_dvalid_i,
    input wire [31:0] sd_rd_data_i
);
    localparam S_IDLE = 5'h01;
    localparam S_DEC = 5'h02;
    localparam S_DATA = 5'h04;
    localparam S_STOPW = 5'h08;
    localparam S_TURN = 5'h10;
    localparam [4:0] ILIM = INIT_LAT[4:0] - 5'd1;
    localparam [4:0] SLIM = SUBS_LAT[4:0] - 5'd1;
    localparam [4:0] RF_ROOM = `PTS_RF_DEPTH - `PTS_LINE_WORDS;

    function [4:0] rr_pick;
        input [4:0] r;
        input [2:0] last;
        integer i;
        reg [2:0] j;
        reg [3:0] s;
        begin
            rr_pick = 5'h00;
            for (i = 5; i >= 1; i = i - 1) begin
                // Sum kept one bit wider so the wrap past index 4 is not lost
                s = {1'b0, last} + {1'b0, i[2:0]};
                j = (s >= 4'd5) ? s[2:0] - 3'd5 : s[2:0];
                if (r[j])
                    rr_pick = 5'h01 << j;
            end
        end
    endfunction

    function [2:0] enc5;
        input [4:0] g;
        begin
            enc5 = g[4] ? 3'd4 : g[3] ? 3'd3 : g[2] ? 3'd2 : g[1] ? 3'd1 : 3'd0;
        end
    endfunction

    reg [4:0] st_r;
    reg frame_q_r;
    reg [3:0] cmd_r;
    reg [29:0] addr_r;
    reg cfg_r;
    reg wr_r;
    reg [2:0] fn_r;
    reg cont_r;
    reg one_r;
    reg [2:0] start_r;
    reg [3:0] remain_r;
    reg viol_r;
    reg locked_r;
    reg first_r;
    reg [4:0] lat_r;
    reg [26:0] fa_r;
    reg [26:0] ra_r;
    reg fetch_first_r;
    reg fetch_done_r;
    reg rx_busy_r;
    reg [2:0] beat_r;
    reg [2:0] kb_lo_r;
    reg [2:0] kb_hi_r;
    reg discard_r;
    reg gv_r;
    reg [26:0] gl_r;
    reg [4:0] gnt_r;
    reg [2:0] last_r;

    wire [3:0] cmd = cbe_n_i;
    wire is_rd = (cmd == `PTS_CMD_MRD) || (cmd == `PTS_CMD_MRL) || (cmd == `PTS_CMD_MRM);
    // Write and write-and-invalidate share one path
    wire is_wr = (cmd == `PTS_CMD_MWR) || (cmd == `PTS_CMD_MWI);
    wire mem_hit = (ad_i[31:MEM_AW] == MEM_BASE[31:MEM_AW]) && (is_rd || is_wr);
    wire fn_ok = (ad_i[10:8] == `PTS_FN_USB) || (ad_i[10:8] == `PTS_FN_GPIO);
    wire cfg_hit = idsel_i && (ad_i[1:0] == 2'b00) && fn_ok
        && ((cmd == `PTS_CMD_CRD) || (cmd == `PTS_CMD_CWR));
    wire addr_ph = st_r[0] && !frame_n_i && frame_q_r;

    wire in_data = st_r[2];
    wire rd_mem = !wr_r && !cfg_r;
    wire tmo = lat_r == (first_r ? ILIM : SLIM);

    wire wf_in_ready;
    wire wf_out_valid;
    wire [65:0] wf_out_data;
    wire [4:0] wf_count;
    wire rf_in_ready;
    wire rf_out_valid;
    wire [31:0] rf_out_data;
    wire [4:0] rf_count;
    wire wf_pop;

    wire trdy = in_data && !tmo
        && (cfg_r || (wr_r ? wf_in_ready : rf_out_valid));
    wire last = cfg_r || (rd_mem && !cont_r && remain_r == 4'd1);
    wire xfer = trdy && !irdy_n_i;
    wire stop = st_r[3] || (in_data && (tmo || (trdy && last)));

    assign devsel_n_o = !(in_data || st_r[3]);
    assign trdy_n_o = !trdy;
    assign stop_n_o = !stop;
    assign ctl_oe = in_data || st_r[3] || st_r[4];
    assign ad_oe = !wr_r && in_data && !(cfg_r && cmd_r == `PTS_CMD_CWR);
    assign ad_o = cfg_r ? ((addr_r[5:0] == 6'h00)
        ? (fn_r == `PTS_FN_USB ? ID_USB : ID_GPIO) : 32'h00000000) : rf_out_data;

    always @(posedge clk) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            frame_q_r <= 1'b1;
            cmd_r <= 4'h0;
            addr_r <= 30'h00000000;
            cfg_r <= 1'b0;
            wr_r <= 1'b0;
            fn_r <= 3'h0;
            cont_r <= 1'b0;
            one_r <= 1'b0;
            start_r <= 3'h0;
            remain_r <= 4'h0;
            viol_r <= 1'b0;
            first_r <= 1'b1;
            lat_r <= 5'h00;
        end else begin
            frame_q_r <= frame_n_i;
            case (st_r)
                S_IDLE: begin
                    if (addr_ph && (mem_hit || cfg_hit)) begin
                        st_r <= S_DEC;
                        cmd_r <= cmd;
                        addr_r <= ad_i[31:2];
                        cfg_r <= cfg_hit;
                        wr_r <= is_wr || cmd == `PTS_CMD_CWR;
                        fn_r <= ad_i[10:8];
                        cont_r <= pf_en_i && is_rd;
                        one_r <= !pf_en_i && cmd == `PTS_CMD_MRD;
                        start_r <= ad_i[4:2];
                        remain_r <= (!pf_en_i && cmd == `PTS_CMD_MRD) ? 4'd1
                            : 4'd8 - {1'b0, ad_i[4:2]};
                        // A non-owner sees the lock already held at its address phase
                        viol_r <= locked_r && !lock_n_i;
                        first_r <= 1'b1;
                        lat_r <= 5'h00;
                    end
                end
                // Medium decode: device select one cycle after the fast slot
                S_DEC: st_r <= viol_r ? S_STOPW : S_DATA;
                S_DATA: begin
                    if (xfer) begin
                        addr_r <= addr_r + 1'b1;
                        first_r <= 1'b0;
                        lat_r <= 5'h00;
                        remain_r <= remain_r - 1'b1;
                    end else if (!tmo) begin
                        lat_r <= lat_r + 1'b1;
                    end
                    if (xfer && frame_n_i)
                        st_r <= S_TURN;
                    else if ((xfer && last) || tmo)
                        st_r <= S_STOPW;
                end
                S_STOPW: begin
                    if (frame_n_i)
                        st_r <= S_TURN;
                end
                S_TURN: st_r <= S_IDLE;
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Lock is taken by a completed locked access and dropped when bus and lock are idle
    always @(posedge clk) begin
        if (!rst_n)
            locked_r <= 1'b0;
        else if (in_data && xfer && !lock_n_i && !viol_r)
            locked_r <= 1'b1;
        else if (lock_n_i && frame_n_i && st_r[0])
            locked_r <= 1'b0;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            par_o_r <= 1'b0;
            par_oe_r <= 1'b0;
            sys_err_r <= 1'b0;
        end else begin
            par_o_r <= ^{ad_o, cbe_n_i};
            par_oe_r <= ad_oe;
            if (!serr_n_i)
                sys_err_r <= 1'b1;
        end
    end

    // Posted write path
    wire wf_push = in_data && wr_r && !cfg_r && !irdy_n_i && !tmo;
    pts_fifo #(.W(66), .D(`PTS_WF_DEPTH), .AW(4)) u_wf (
        .clk(clk),
        .rst_n(rst_n),
        .flush(1'b0),
        .in_valid(wf_push),
        .in_ready(wf_in_ready),
        .in_data({addr_r, ~cbe_n_i, ad_i}),
        .out_valid(wf_out_valid),
        .out_ready(wf_pop),
        .out_data(wf_out_data),
        .count(wf_count)
    );

    wire [26:0] wf_line = wf_out_data[65:39];
    wire [2:0] wf_idx = wf_out_data[38:36];
    assign wf_pop = wf_out_valid && !sd_wr_valid_r && (!gv_r || wf_line == gl_r);
    wire writes_done = !wf_out_valid && !gv_r && !sd_wr_valid_r;
    assign sd_wr_addr = {gl_r, 5'h00};
    integer k;

    always @(posedge clk) begin
        if (!rst_n) begin
            gv_r <= 1'b0;
            gl_r <= 27'h0000000;
            sd_wr_valid_r <= 1'b0;
            sd_wr_data_r <= 256'h0;
            sd_wr_mask_r <= 32'h00000000;
        end else if (sd_wr_valid_r) begin
            if (sd_wr_ready_i) begin
                sd_wr_valid_r <= 1'b0;
                gv_r <= 1'b0;
                sd_wr_mask_r <= 32'h00000000;
            end
        end else if (wf_pop) begin
            gv_r <= 1'b1;
            gl_r <= wf_line;
            for (k = 0; k < 4; k = k + 1) begin
                if (wf_out_data[32+k]) begin
                    sd_wr_data_r[wf_idx*32+k*8 +: 8] <= wf_out_data[k*8 +: 8];
                    sd_wr_mask_r[wf_idx*4+k] <= 1'b1;
                end
            end
        end else if (gv_r) begin
            // Line ends when the next word lies elsewhere or the FIFO runs dry
            sd_wr_valid_r <= 1'b1;
        end
    end

    // Read prefetch path
    wire rf_flush = st_r[4] && rd_mem;
    wire [2:0] lo_n = fetch_first_r ? start_r : 3'd0;
    wire can_fetch = in_data && rd_mem && writes_done && !sd_rd_req_r && !rx_busy_r
        && !discard_r && !fetch_done_r && rf_count <= RF_ROOM;
    wire rf_push = sd_rd_dvalid_i && rx_busy_r && !discard_r && rf_in_ready
        && beat_r >= kb_lo_r && beat_r <= kb_hi_r;
    assign sd_rd_addr = {ra_r, 5'h00};

    pts_fifo #(.W(32), .D(`PTS_RF_DEPTH), .AW(4)) u_rf (
        .clk(clk),
        .rst_n(rst_n),
        .flush(rf_flush),
        .in_valid(rf_push),
        .in_ready(rf_in_ready),
        .in_data(sd_rd_data_i),
        .out_valid(rf_out_valid),
        .out_ready(xfer && rd_mem),
        .out_data(rf_out_data),
        .count(rf_count)
    );

    always @(posedge clk) begin
        if (!rst_n) begin
            sd_rd_req_r <= 1'b0;
            ra_r <= 27'h0000000;
            fa_r <= 27'h0000000;
            fetch_first_r <= 1'b0;
            fetch_done_r <= 1'b1;
            rx_busy_r <= 1'b0;
            beat_r <= 3'h0;
            kb_lo_r <= 3'h0;
            kb_hi_r <= 3'h0;
            discard_r <= 1'b0;
        end else begin
            if (addr_ph) begin
                fa_r <= ad_i[31:5];
                fetch_first_r <= 1'b1;
                fetch_done_r <= 1'b0;
            end else if (can_fetch) begin
                sd_rd_req_r <= 1'b1;
                ra_r <= fa_r;
                fa_r <= fa_r + 1'b1;
                kb_lo_r <= lo_n;
                kb_hi_r <= one_r ? lo_n : 3'd7;
                fetch_first_r <= 1'b0;
                fetch_done_r <= !cont_r;
                rx_busy_r <= 1'b1;
                beat_r <= 3'h0;
            end
            if (sd_rd_req_r && sd_rd_ready_i)
                sd_rd_req_r <= 1'b0;
            if (sd_rd_dvalid_i && rx_busy_r) begin
                beat_r <= beat_r + 1'b1;
                if (beat_r == 3'd7)
                    rx_busy_r <= 1'b0;
            end
            // Data still in flight at the end of a read is dropped as it returns
            if (rf_flush && (rx_busy_r || sd_rd_req_r))
                discard_r <= 1'b1;
            else if (!rx_busy_r && !sd_rd_req_r)
                discard_r <= 1'b0;
        end
    end

    // Arbiter: index 4 is the internal bridge agents
    wire [3:0] pair_en = (4'hf >> (4 - NUM_PAIRS));
    wire [4:0] reqv = {int_req_i, ~req_n_i & pair_en};
    wire bus_idle = frame_n_i && irdy_n_i;
    wire [4:0] pick = (PAIR1_HI != 0 && reqv[1]) ? 5'h02 : rr_pick(reqv, last_r);
    assign gnt_n_o = ~gnt_r[3:0];
    assign int_gnt_o = gnt_r[4];

    always @(posedge clk) begin
        if (!rst_n) begin
            gnt_r <= 5'h00;
            last_r <= 3'd4;
        end else if (bus_idle && (gnt_r & reqv) == 5'h00) begin
            gnt_r <= pick;
            if (pick != 5'h00)
                last_r <= enc5(pick);
        end
    end

    // The PCI clock is the block clock fanned out; no local divider
    assign pci_clk0_o = clk;
    assign pci_clk_conn_o = clk;
    assign clk_stop_ok_o = bus_idle && st_r[0] && wf_count == 5'd0
        && rf_count == 5'd0 && writes_done;
endmodule

/* File: testbench/pts_bridge_props.sv */
`timescale 1ns/1ns
module pts_bridge_props #(
    parameter INIT_LAT = 16
) (
    input wire clk,
    input wire rst_n,
    input wire frame_n_i,
    input wire devsel_n_o,
    input wire trdy_n_o,
    input wire stop_n_o,
    input wire serr_n_i,
    input logic sys_err_r,
    input logic sd_wr_valid_r,
    input wire sd_wr_ready_i,
    input wire [31:0] sd_wr_addr,
    input logic sd_rd_req_r,
    input wire [3:0] gnt_n_o
);
    logic [7:0] wait_cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles claimed without data or stop; bounded by the initial latency timer
    always @(posedge clk) begin
        if (!rst_n || devsel_n_o || !trdy_n_o || !stop_n_o) begin
            wait_cnt_r <= 8'h0;
        end else begin
            wait_cnt_r <= wait_cnt_r + 8'h1;
        end
    end
    sequence s_addr;
        frame_n_i ##1 !frame_n_i;
    endsequence
    sequence s_wr_stall;
        sd_wr_valid_r && !sd_wr_ready_i;
    endsequence
    a_no_fast_decode: assert property (s_addr |=> devsel_n_o)
        else $error("device select one cycle after address");
    a_one_grant: assert property ($onehot0(~gnt_n_o))
        else $error("more than one grant");
    a_wr_aligned: assert property (sd_wr_valid_r |-> sd_wr_addr[4:0] == 5'h0)
        else $error("write request not line aligned");
    a_wr_held: assert property (s_wr_stall |=> sd_wr_valid_r && $stable(sd_wr_addr))
        else $error("write request dropped before ready");
    a_read_after_write: assert property ($rose(sd_rd_req_r) |-> !sd_wr_valid_r)
        else $error("read issued with write pending");
    a_serr_sticky: assert property (!serr_n_i |=> sys_err_r [*4])
        else $error("system error not held");
    a_stop_held: assert property (!stop_n_o && !frame_n_i |=> !stop_n_o)
        else $error("stop released while frame low");
    a_init_latency: assert property (wait_cnt_r <= INIT_LAT + 2)
        else $error("latency timer did not end transfer");
endmodule

bind pts_bridge pts_bridge_props #(.INIT_LAT(INIT_LAT)) pts_bridge_props_i (
    .clk(clk), .rst_n(rst_n), .frame_n_i(frame_n_i), .devsel_n_o(devsel_n_o),
    .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o), .serr_n_i(serr_n_i), .sys_err_r(sys_err_r),
    .sd_wr_valid_r(sd_wr_valid_r), .sd_wr_ready_i(sd_wr_ready_i), .sd_wr_addr(sd_wr_addr),
    .sd_rd_req_r(sd_rd_req_r), .gnt_n_o(gnt_n_o));

/* File: testbench/pts_sdram_model.sv */
`timescale 1ns/1ns
module pts_sdram_model (
    input wire clk,
    input wire rst_n,
    input wire stall,
    input wire wr_valid,
    output logic wr_ready,
    input wire [31:0] wr_addr,
    input wire [255:0] wr_data,
    input wire [31:0] wr_mask,
    input wire rd_req,
    output logic rd_ready,
    input wire [31:0] rd_addr,
    output logic rd_dvalid,
    output logic [31:0] rd_data
);
    logic [31:0] mem [0:255];
    logic [7:0] base_r;
    logic [2:0] beat_r;
    logic busy_r;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'hc0de0000 + i;
        rd_data = 32'h0;
    end
    // Stall backs up posted writes and starves reads, so timers get exercised
    assign wr_ready = !stall;
    assign rd_ready = !stall && !busy_r;
    always @(posedge clk) begin
        rd_dvalid <= 1'b0;
        rd_data <= ~rd_data;
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else begin
            if (wr_valid && wr_ready) begin
                for (int w = 0; w < 8; w++) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wr_mask[4 * w + b]) begin
                            mem[{wr_addr[9:5], 3'(w)}][8 * b +: 8] <= wr_data[32 * w + 8 * b +: 8];
                        end
                    end
                end
            end
            if (busy_r && !stall) begin
                rd_dvalid <= 1'b1;
                rd_data <= mem[base_r + {5'h0, beat_r}];
                beat_r <= beat_r + 3'h1;
                busy_r <= (beat_r != 3'h7);
            end
            if (rd_req && rd_ready) begin
                busy_r <= 1'b1;
                base_r <= {rd_addr[9:5], 3'h0};
                beat_r <= 3'h0;
            end
        end
    end
endmodule

/* File: testbench/pts_bridge_tb.sv */
`timescale 1ns/1ns
`include "pts_consts.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module pts_bridge_tb;
    localparam [31:0] ID_U = 32'h0000a0a1; // Arbitrary value
    localparam [31:0] ID_G = 32'h0000a0a2; // Arbitrary value
    logic clk = 0, rst_n = 0, pf_en_i = 0, frame_n_i = 1, irdy_n_i = 1, idsel_i = 0;
    logic serr_n_i = 1, stall = 0, int_req_i = 0, lock_n_i = 1;
    logic [31:0] ad_i = 32'h0;
    logic [3:0] cbe_n_i = 4'hf, req_n_i = 4'hf, be = 4'h0;
    logic [31:0] wd [0:31], rd [0:31];
    int failures = 0, compares = 0;
    wire [31:0] ad_o, sd_wr_addr, sd_rd_addr, sd_rd_data_i, sd_wr_mask_r;
    wire [255:0] sd_wr_data_r;
    wire [3:0] gnt_n_o;
    wire devsel_n_o, trdy_n_o, stop_n_o, sys_err_r, pci_clk0_o, pci_clk_conn_o;
    wire ad_oe, ctl_oe, par_oe_r, int_gnt_o, clk_stop_ok_o;
    wire sd_wr_valid_r, sd_wr_ready_i, sd_rd_req_r, sd_rd_ready_i, sd_rd_dvalid_i;
    always #50 clk = ~clk;
    pts_bridge #(.ID_USB(ID_U), .ID_GPIO(ID_G)) pts_bridge_i (.clk(clk), .rst_n(rst_n),
        .pf_en_i(pf_en_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .cbe_n_i(cbe_n_i),
        .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i), .idsel_i(idsel_i), .lock_n_i(lock_n_i),
        .devsel_n_o(devsel_n_o), .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o), .ctl_oe(ctl_oe),
        .par_o_r(), .par_oe_r(par_oe_r), .serr_n_i(serr_n_i), .sys_err_r(sys_err_r),
        .req_n_i(req_n_i), .gnt_n_o(gnt_n_o), .int_req_i(int_req_i), .int_gnt_o(int_gnt_o),
        .pci_clk0_o(pci_clk0_o), .pci_clk_conn_o(pci_clk_conn_o), .clk_stop_ok_o(clk_stop_ok_o),
        .sd_wr_valid_r(sd_wr_valid_r), .sd_wr_ready_i(sd_wr_ready_i), .sd_wr_addr(sd_wr_addr),
        .sd_wr_data_r(sd_wr_data_r), .sd_wr_mask_r(sd_wr_mask_r), .sd_rd_req_r(sd_rd_req_r),
        .sd_rd_ready_i(sd_rd_ready_i), .sd_rd_addr(sd_rd_addr),
        .sd_rd_dvalid_i(sd_rd_dvalid_i), .sd_rd_data_i(sd_rd_data_i));
    pts_sdram_model pts_sdram_model_i (.clk(clk), .rst_n(rst_n), .stall(stall),
        .wr_valid(sd_wr_valid_r), .wr_ready(sd_wr_ready_i), .wr_addr(sd_wr_addr),
        .wr_data(sd_wr_data_r), .wr_mask(sd_wr_mask_r), .rd_req(sd_rd_req_r),
        .rd_ready(sd_rd_ready_i), .rd_addr(sd_rd_addr), .rd_dvalid(sd_rd_dvalid_i),
        .rd_data(sd_rd_data_i));
    function automatic [31:0] init_w(input int i);
        return 32'hc0de0000 + i;
    endfunction
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Master side: outputs sampled at the falling edge hold what the next rising edge sees
    task automatic pci(input logic [3:0] cmd, input logic [31:0] adr, input int n,
                       input logic cfg, output int got);
        int k;
        logic st;
        got = 0;
        st = 0;
        @(posedge clk);
        frame_n_i <= 0;
        ad_i <= adr;
        cbe_n_i <= cmd;
        idsel_i <= cfg;
        @(posedge clk);
        irdy_n_i <= 0;
        cbe_n_i <= be;
        ad_i <= wd[0];
        idsel_i <= 0;
        frame_n_i <= (n == 1);
        for (k = 0; k < 100; k++) begin
            @(negedge clk);
            st = !stop_n_o;
            if (!trdy_n_o) begin
                rd[got] = ad_o;
                got++;
            end
            @(posedge clk);
            if (st || got == n) break;
            ad_i <= wd[got];
            frame_n_i <= (got == n - 1);
        end
        if (k == 100) begin
            failures++;
            conclude;
        end
        if (!frame_n_i) begin
            frame_n_i <= 1;
            @(posedge clk);
        end
        irdy_n_i <= 1;
        ad_i <= ~ad_i;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_gnt(input logic [3:0] e);
        int k;
        for (k = 0; k < 20 && gnt_n_o !== e; k++) @(negedge clk);
        `CHK("grant", e, gnt_n_o)
        if (k == 20) conclude;
    endtask
    // A retried single read is repeated, as a real master would
    task automatic pci_rt(input logic [3:0] cmd, input logic [31:0] adr, output int got);
        int r;
        got = 0;
        for (r = 0; r < 4 && got == 0; r++) pci(cmd, adr, 1, 0, got);
    endtask
    task automatic t_write_read;
        int n;
        pci(`PTS_CMD_MWR, 32'ha0000008, 2, 0, n);
        `CHK("write count", 2, n)
        be = 4'hc;
        pci(`PTS_CMD_MWI, 32'ha0000010, 1, 0, n);
        be = 4'h0;
        pci(`PTS_CMD_MRD, 32'ha0000008, 4, 0, n);
        `CHK("plain read count", 1, n)
        `CHK("read back", wd[0], rd[0])
        pci(`PTS_CMD_MRD, 32'ha0000010, 1, 0, n);
        `CHK("masked word", (init_w(4) & 32'hffff0000) | (wd[0] & 32'hffff), rd[0])
        $display("write read done");
    endtask
    task automatic t_lines;
        int n;
        pci(`PTS_CMD_MRL, 32'ha0000018, 8, 0, n);
        `CHK("line read count", 2, n)
        pci(`PTS_CMD_MRM, 32'ha0000060, 8, 0, n);
        `CHK("multiple last", init_w(31), rd[7])
        pf_en_i <= 1;
        pci(`PTS_CMD_MRM, 32'ha0000078, 6, 0, n);
        `CHK("prefetch cross", init_w(35), rd[5])
        pci(`PTS_CMD_MWR, 32'ha0000084, 1, 0, n);
        pci(`PTS_CMD_MRD, 32'ha0000080, 3, 0, n);
        `CHK("fresh after flush", wd[0], rd[1])
        pf_en_i <= 0;
        $display("line reads done");
    endtask
    task automatic t_cfg;
        int n;
        pci(`PTS_CMD_CRD, {19'h0, 1'b1, 1'b0, `PTS_FN_USB, 8'h00}, 1, 1, n);
        `CHK("usb id", ID_U, rd[0])
        pci(`PTS_CMD_CRD, {19'h0, 1'b1, 1'b0, `PTS_FN_GPIO, 8'h00}, 1, 1, n);
        `CHK("gpio id", ID_G, rd[0])
        $display("config done");
    endtask
    task automatic t_stall;
        int n;
        int m;
        stall <= 1;
        pci(`PTS_CMD_MRD, 32'ha0000040, 1, 0, n);
        `CHK("retry count", 0, n)
        pci(`PTS_CMD_MWR, 32'ha0000100, 32, 0, m);
        `CHK("full disconnect", 1'b1, (m >= 16 && m < 32))
        @(negedge clk);
        `CHK("clock stop held", 1'b0, clk_stop_ok_o)
        @(posedge clk);
        stall <= 0;
        pci_rt(`PTS_CMD_MRD, 32'ha0000040, n);
        `CHK("after retry", init_w(16), rd[0])
        pci_rt(`PTS_CMD_MRD, 32'ha0000100 + 32'(4 * (m - 1)), n);
        `CHK("last posted", wd[m - 1], rd[0])
        $display("stall done");
    endtask
    task automatic t_misc;
        int n;
        @(negedge clk);
        `CHK("clock stop ok", 1'b1, clk_stop_ok_o)
        `CHK("idle drive", 3'h0, {ad_oe, ctl_oe, par_oe_r})
        @(posedge clk);
        lock_n_i <= 0;
        pci(`PTS_CMD_MWR, 32'ha0000200, 1, 0, n);
        pci(`PTS_CMD_MWR, 32'ha0000204, 1, 0, n);
        `CHK("locked retry", 0, n)
        lock_n_i <= 1;
        pci(`PTS_CMD_MWR, 32'ha0000204, 1, 0, n);
        `CHK("lock released", 1, n)
        serr_n_i <= 0;
        @(posedge clk);
        serr_n_i <= 1;
        repeat (3) @(negedge clk);
        `CHK("sys err", 1'b1, sys_err_r)
        @(posedge clk);
        req_n_i <= 4'hc;
        wait_gnt(4'hd);
        @(posedge clk);
        req_n_i <= 4'hb;
        wait_gnt(4'hb);
        @(posedge clk);
        req_n_i <= 4'hf;
        int_req_i <= 1;
        wait_gnt(4'hf);
        `CHK("internal grant", 1'b1, int_gnt_o)
        @(posedge clk);
        int_req_i <= 0;
        #10;
        `CHK("clock out", clk, pci_clk0_o)
        `CHK("clock conn", clk, pci_clk_conn_o)
        $display("misc done");
    endtask
    initial begin
        for (int i = 0; i < 32; i++) wd[i] = 32'h5a5a0000 + i;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        t_write_read;
        t_lines;
        t_cfg;
        t_stall;
        t_misc;
        conclude;
    end
endmodule
